/* File: logic/pmd_pkg.sv */
// Purpose: shared constants and types for the peripheral disable register
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes:   offsets and reset values named once here
package pmd_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  PMD_ONE_OFFSET = 4'h0;   // peripheral_disable_one
	localparam logic [15:0] PMD_ONE_RESET  = 16'h0000;
	localparam logic [15:0] PMD_ONE_MASK   = 16'h38fb; // implemented bits

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PMD_TIMER_THREE_BIT = 13;
	localparam int PMD_TIMER_TWO_BIT   = 12;
	localparam int PMD_TIMER_ONE_BIT   = 11;
	localparam int PMD_I2C_ONE_BIT     = 7;
	localparam int PMD_UART_TWO_BIT    = 6;
	localparam int PMD_UART_ONE_BIT    = 5;
	localparam int PMD_SPI_TWO_BIT     = 4;
	localparam int PMD_SPI_ONE_BIT     = 3;
	localparam int PMD_CAN_ONE_BIT     = 1;
	localparam int PMD_ADC_ONE_BIT     = 0;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] PMD_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PMD_RESP_SLVERR = 2'h2;

	// module-disable outputs, one per peripheral
	typedef struct packed {
		logic timer_three_off;
		logic timer_two_off;
		logic timer_one_off;
		logic i2c_unit_one_off;
		logic uart_two_off;
		logic uart_one_off;
		logic spi_unit_two_off;
		logic spi_unit_one_off;
		logic can_unit_one_off;
		logic adc_unit_one_off;
	} pmd_off_s;

endpackage

/* File: logic/pmd_regs.sv */
// Purpose: peripheral module disable register behind an AXI4-Lite slave
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes:   one write and one read in flight at most; other addresses map to SLVERR
`timescale 1ns/100ps
module pmd_regs
	import pmd_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output pmd_pkg::pmd_off_s      module_off
);
	import pmd_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        aw_held_reg;     // write address captured
	logic        w_held_reg;      // write data captured
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;
	logic [15:0] disable_reg;
	logic [15:0] disable_next;

	// ----------------------------------------------------------------
	// write path decode
	// ----------------------------------------------------------------
	// ready while nothing held and no response pending
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;

	wire         aw_take   = s_axi_awvalid && s_axi_awready;
	wire         w_take    = s_axi_wvalid && s_axi_wready;
	wire         aw_have   = aw_held_reg || aw_take;
	wire         w_have    = w_held_reg || w_take;
	wire         wr_fire   = aw_have && w_have;
	wire [31:0]  wr_addr   = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0]  wr_data   = w_held_reg ? wdata_reg : s_axi_wdata;
	wire [3:0]   wr_strb   = w_held_reg ? wstrb_reg : s_axi_wstrb;
	// only the one aligned word of the register is a hit
	wire         wr_hit    = (wr_addr == {28'h0, PMD_ONE_OFFSET});
	wire [15:0]  wr_bytes  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// merge write under byte strobes; unimplemented bits forced to zero
	// bits 15-14, 10-8 and 2 dropped
	assign disable_next = ((disable_reg & ~wr_bytes) |
	                       (wr_data[15:0] & wr_bytes)) & PMD_ONE_MASK;

	// ----------------------------------------------------------------
	// write channel registers
	// ----------------------------------------------------------------
	// capture address and data in either order, answer once both seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 32'h0;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= PMD_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata;
					wstrb_reg  <= s_axi_wstrb;
				end
				if (bvalid_reg && s_axi_bready) begin
					bvalid_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// disable register
	// ----------------------------------------------------------------
	// all bits reset to zero, every module enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			disable_reg <= PMD_ONE_RESET;
		end else if (wr_fire && wr_hit) begin
			disable_reg <= disable_next;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_reg;

	wire         ar_take = s_axi_arvalid && s_axi_arready;
	wire         rd_hit  = (s_axi_araddr == {28'h0, PMD_ONE_OFFSET});
	// unimplemented bits read zero via mask
	wire [31:0]  rd_word = {16'h0, disable_reg & PMD_ONE_MASK};

	// answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= PMD_RESP_OKAY;
			rdata_reg  <= 32'h0;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_hit ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
			rdata_reg  <= rd_hit ? rd_word : 32'h0;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// ----------------------------------------------------------------
	// module-disable outputs, straight from register bits
	// ----------------------------------------------------------------
	// third timer
	assign module_off.timer_three_off  = disable_reg[PMD_TIMER_THREE_BIT];
	assign module_off.timer_two_off    = disable_reg[PMD_TIMER_TWO_BIT];
	assign module_off.timer_one_off    = disable_reg[PMD_TIMER_ONE_BIT];
	assign module_off.i2c_unit_one_off = disable_reg[PMD_I2C_ONE_BIT];
	assign module_off.uart_two_off     = disable_reg[PMD_UART_TWO_BIT];
	assign module_off.uart_one_off     = disable_reg[PMD_UART_ONE_BIT];
	assign module_off.spi_unit_two_off = disable_reg[PMD_SPI_TWO_BIT];
	assign module_off.spi_unit_one_off = disable_reg[PMD_SPI_ONE_BIT];
	assign module_off.can_unit_one_off = disable_reg[PMD_CAN_ONE_BIT];
	assign module_off.adc_unit_one_off = disable_reg[PMD_ADC_ONE_BIT];

endmodule // pmd_regs

/* File: verification/pmd_regs_properties.sv */
// Purpose: port properties of the peripheral disable register
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes:   bound into pmd_regs, ports joined by name
`timescale 1ns/100ps
module pmd_regs_properties
	import pmd_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire pmd_pkg::pmd_off_s module_off
);
	// ------------------------------------------------------------
	// handshake and field checks
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("bvalid stuck");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("no rvalid");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	a_rd_slverr: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr != 32'h0 |=> s_axi_rresp == PMD_RESP_SLVERR &&
		s_axi_rdata == 32'h0) else $error("bad read not refused");
	a_rd_unimpl:
	assert property (s_axi_rvalid |-> s_axi_rdata[10:8] == 3'h0 &&
		!s_axi_rdata[2]) else $error("unimplemented bit set");
	a_off_cause:
	assert property ($past(aresetn) && !$stable(module_off) |->
		$rose(s_axi_bvalid) &&
		s_axi_bresp == PMD_RESP_OKAY) else $error("output moved alone");
	a_off_readback:
	assert property ($rose(s_axi_rvalid) && !s_axi_bvalid &&
		s_axi_rresp == PMD_RESP_OKAY |-> s_axi_rdata[13:0] ==
		{module_off[9:7], 3'h0, module_off[6:2], 1'b0, module_off[1:0]})
		else $error("output differs from register");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rresp == PMD_RESP_OKAY);
	c_refuse: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
endmodule // pmd_regs_properties

bind pmd_regs pmd_regs_properties u_props (.*);

/* File: verification/test_peripheral_module_disable.sv */
// Purpose: register tests for the peripheral disable block
// Assumes: AXI4-Lite master driven right after each rising edge
// Notes:   expected values follow the documented bit map
`timescale 1ns/100ps
module test_peripheral_module_disable;
	import pmd_pkg::*;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	pmd_off_s    module_off;
	int          miscompares = 0, samples_checked = 0, n;
	pmd_regs u_dut (.*);
	// clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		repeat (5000) @(posedge aclk);
		miscompares++;
		wrap_up;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	function automatic logic [31:0] off_of(input logic [31:0] d);
		return {22'h0, d[13:11], d[7:3], d[1:0]};
	endfunction
	// write: both halves offered together, bready held until bvalid
	task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (n == 50) miscompares++;
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	task rdt(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (n == 50) miscompares++;
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// main sequence
	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
		{s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdt(32'h0);
		chk(rd, 32'h0);
		chk({22'h0, module_off}, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			wr(32'h0, 32'h1 << i, 4'hf);
			rdt(32'h0);
			chk(rd, off_of(32'h1 << i) == 0 ? 32'h0 : 32'h1 << i);
			chk({22'h0, module_off}, off_of(32'h1 << i));
		end
		$display("walking bit test done");
		wr(32'h0, 32'hffffffff, 4'hf);
		chk({30'h0, resp}, {30'h0, PMD_RESP_OKAY});
		rdt(32'h0);
		chk(rd, 32'h000038fb);
		wr(32'h0, 32'h0, 4'h1);
		rdt(32'h0);
		chk(rd, 32'h00003800);
		wr(32'h4, 32'h0, 4'hf);
		chk({30'h0, resp}, {30'h0, PMD_RESP_SLVERR});
		chk({22'h0, module_off}, off_of(32'h3800));
		rdt(32'h4);
		chk(rd ^ {30'h0, resp}, {30'h0, PMD_RESP_SLVERR});
		$display("strobe and refusal test done");
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({22'h0, module_off}, 32'h0);
		$display("second reset test done");
		wrap_up;
	end
endmodule // test_peripheral_module_disable
